/* rtl/prr_recorder.sv */
// Profiling event ring recorder: stores records, moves head, reloads counters
// Function
// - Raise threshold interrupt when enabled and buffer use plus one record exceeds threshold, maybe late.
// - Record store, report and reload may lag the retiring instruction.
// - Reload each stored event's counter with its interval, optional random low bits.
// - Reload only if head advanced or missed count incremented.
// - Counter overrun below -1 is subtracted from the reload value.
// - Minimum reload interval for all but value samples, shown in interval field.
// - Hardware owns head; never writes tail or region tail to head.
// - On cached full or threshold, reload tail from memory and recheck.
// - After continuous stop, missed count tells whether records wrapped.
// - Record timestamp is the counter copy, zero-extended to 64 bits.
// - Timestamp counter free-runs at 100 MHz from init, no reset or write.
// - Two-bit field reports timestamp width: 40, 48, 56 or 64 bits.
// - Records are a fixed 32 bytes, reported in a capability field.
// - Reserved and undefined record fields are written as zero.
// - Layout: id, core, flags, data, instr address, event address, timestamp.
// - Event identifier is 1 to 255, never zero.
// - Core byte copied from the configuration core identifier field.
// - Instruction address is the effective address before segment base.
// - Timestamp written only if profiling started with timestamp enabled.
// - Identifier codes 1 to 6 and 255 for the defined events.
// - Buffer full when advancing head by one record would equal tail.
// - Full: synchronized mode holds head and counts; continuous advances and counts.
// - Record collection starts once the event counter is negative.
`default_nettype none
module prr_recorder (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic prof_enable,
	input wire logic continuous_mode_flag,
	input wire logic timestamp_enable_flag,
	input wire logic thr_int_enable,
	input wire logic [7:0] core_identifier_field,
	input wire logic [63:0] buf_base,
	input wire logic [31:0] buf_size,
	input wire logic [31:0] threshold,
	input wire logic [31:0] head_init,
	input wire logic [63:0] missed_init,
	input wire logic evt_valid,
	input wire prr_pkg::prr_event_t evt,
	output logic evt_ready,
	output logic mem_wr_valid,
	output logic [63:0] mem_wr_addr,
	output prr_pkg::prr_record_t mem_wr_data,
	input wire logic mem_wr_ready,
	output logic tail_rd_req,
	input wire logic tail_rd_valid,
	input wire logic [31:0] tail_rd_data,
	output logic [31:0] head_ptr,
	output logic [63:0] missed_record_count,
	output logic reload_valid,
	output prr_pkg::prr_reload_t reload,
	output logic [31:0] event_interval_field,
	output logic threshold_irq,
	output logic [1:0] timestamp_width_field,
	output logic [7:0] record_size_field
);
	// =====================================
	// Helpers
	function automatic logic [31:0] adv(input logic [31:0] h, input logic [31:0] sz);
		logic [31:0] n;
		n = h + prr_pkg::REC_BYTES;
		return (n >= sz) ? 32'h0 : n;
	endfunction

	function automatic logic [31:0] used(input logic [31:0] h, input logic [31:0] t,
			input logic [31:0] sz);
		return (h >= t) ? h - t : sz - t + h;
	endfunction

	function automatic logic [31:0] calc_reload(input prr_pkg::prr_event_t ev,
			input logic [15:0] rnd);
		logic signed [33:0] v;
		logic [31:0] r;
		v = $signed({2'b00, ev.interval});
		if (ev.count < $signed(prr_pkg::OVERRUN_EDGE)) begin
			v = v + 34'sd1 + 34'(ev.count);
		end
		r = (v < 34'sd0) ? 32'h0 : v[31:0];
		if (ev.rand_en) begin
			r[prr_pkg::RAND_BITS-1:0] = rnd[prr_pkg::RAND_BITS-1:0];
		end
		if (ev.id != prr_pkg::ID_VALUE && r < prr_pkg::MIN_INTERVAL) begin
			r = prr_pkg::MIN_INTERVAL;
		end
		return r;
	endfunction

	function automatic prr_pkg::prr_record_t build(input prr_pkg::prr_entry_t e,
			input logic [7:0] core, input logic ts_on);
		prr_pkg::prr_record_t r;
		r.id = e.ev.id;
		r.core = core;
		r.flags = e.ev.flags;
		r.data = e.ev.data;
		r.iaddr = e.ev.iaddr;
		r.eaddr = e.ev.eaddr;
		r.ts = ts_on ? e.ts : 64'h0;
		if (e.ev.id == prr_pkg::ID_INSTR) begin
			r.flags = 16'h0;
			r.data = 32'h0;
			r.eaddr = 64'h0;
		end
		return r;
	endfunction

	// =====================================
	// Intake, timestamp and buffer
	typedef enum logic [2:0] {ST_IDLE, ST_CHECK, ST_FETCH, ST_WAIT, ST_STORE, ST_RELOAD} prr_state_t;

	prr_state_t state, next_state;
	logic [63:0] stamp;
	prr_pkg::prr_entry_t in_ent, ent;
	logic in_ok, ent_valid, pop;
	logic prof_q, continuous_mode_flag_q, ts_q;
	logic next_prof_q, next_continuous_mode_flag_q, next_ts_q;
	logic [31:0] tail_c, next_tail_c, next_head;
	logic [63:0] next_missed;
	logic fresh, next_fresh, cause, next_cause;
	logic next_wr_valid, next_rd_req, next_rl_valid, next_irq;
	logic [63:0] next_wr_addr;
	prr_pkg::prr_record_t next_wr_data;
	prr_pkg::prr_reload_t next_rl;
	logic [31:0] next_ivl;
	logic [15:0] lfsr, next_lfsr;
	logic full_c, thr_c, start;

	prr_tsc u_tsc (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.stamp(stamp)
	);

	// Only events whose counter went negative and carry a valid id enter
	assign in_ok = evt_valid & prof_q & (evt.count < 32'sd0)
		& (evt.id != prr_pkg::ID_INVALID);
	assign in_ent = '{ev: evt, ts: stamp};

	// Buffering lets the store trail the retiring instruction
	prr_buf u_buf (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.in_valid(in_ok),
		.in_data(in_ent),
		.in_ready(evt_ready),
		.out_valid(ent_valid),
		.out_data(ent),
		.out_ready(pop)
	);

	// =====================================
	// Store sequencer
	always_comb begin
		start = prof_enable & ~prof_q;
		pop = state == ST_RELOAD;
		full_c = adv(head_ptr, buf_size) == tail_c;
		thr_c = used(head_ptr, tail_c, buf_size) + prr_pkg::REC_BYTES > threshold;
		next_state = state;
		next_prof_q = prof_enable;
		next_continuous_mode_flag_q = start ? continuous_mode_flag : continuous_mode_flag_q;
		next_ts_q = start ? timestamp_enable_flag : ts_q;
		next_head = start ? head_init : head_ptr;
		next_missed = start ? missed_init : missed_record_count;
		next_tail_c = start ? head_init : tail_c;
		next_fresh = fresh;
		next_cause = cause;
		next_wr_valid = mem_wr_valid;
		next_wr_addr = mem_wr_addr;
		next_wr_data = mem_wr_data;
		next_rd_req = 1'b0;
		next_rl_valid = 1'b0;
		next_rl = reload;
		next_ivl = event_interval_field;
		next_irq = 1'b0;
		next_lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
		case (state)
			ST_IDLE: begin
				next_fresh = 1'b0;
				next_cause = 1'b0;
				if (ent_valid & prof_q) begin
					next_state = ST_CHECK;
				end
			end
			ST_CHECK: begin
				if ((full_c | thr_c) & ~fresh) begin
					next_state = ST_FETCH;
				end else begin
					next_irq = thr_int_enable & thr_c;
					if (full_c & ~continuous_mode_flag_q) begin
						next_missed = missed_record_count + 64'h1;
						next_cause = 1'b1;
						next_state = ST_RELOAD;
					end else begin
						next_wr_valid = 1'b1;
						next_wr_addr = buf_base + 64'(head_ptr);
						next_wr_data = build(ent, core_identifier_field, ts_q);
						next_state = ST_STORE;
					end
				end
			end
			ST_FETCH: begin
				next_rd_req = 1'b1;
				next_state = ST_WAIT;
			end
			ST_WAIT: begin
				if (tail_rd_valid) begin
					next_tail_c = tail_rd_data;
					next_fresh = 1'b1;
					next_state = ST_CHECK;
				end
			end
			ST_STORE: begin
				if (mem_wr_ready) begin
					next_wr_valid = 1'b0;
					next_head = adv(head_ptr, buf_size);
					if (full_c) begin
						next_missed = missed_record_count + 64'h1;
					end
					next_cause = 1'b1;
					next_state = ST_RELOAD;
				end
			end
			ST_RELOAD: begin
				if (cause) begin
					next_rl_valid = 1'b1;
					next_rl = '{slot: ent.ev.slot, value: calc_reload(ent.ev, lfsr)};
					next_ivl = next_rl.value;
				end
				next_state = ST_IDLE;
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			state <= ST_IDLE;
			prof_q <= 1'b0;
			continuous_mode_flag_q <= 1'b0;
			ts_q <= 1'b0;
			head_ptr <= prr_pkg::HEAD_RST;
			missed_record_count <= prr_pkg::MISSED_RST;
			tail_c <= prr_pkg::HEAD_RST;
			fresh <= 1'b0;
			cause <= 1'b0;
			mem_wr_valid <= 1'b0;
			mem_wr_addr <= 64'h0;
			mem_wr_data <= '0;
			tail_rd_req <= 1'b0;
			reload_valid <= 1'b0;
			reload <= '0;
			event_interval_field <= 32'h0;
			threshold_irq <= 1'b0;
			lfsr <= prr_pkg::LFSR_RST;
			timestamp_width_field <= prr_pkg::TS_WIDTH_CODE;
			record_size_field <= prr_pkg::REC_SIZE_FIELD;
		end else begin
			state <= next_state;
			prof_q <= next_prof_q;
			continuous_mode_flag_q <= next_continuous_mode_flag_q;
			ts_q <= next_ts_q;
			head_ptr <= next_head;
			missed_record_count <= next_missed;
			tail_c <= next_tail_c;
			fresh <= next_fresh;
			cause <= next_cause;
			mem_wr_valid <= next_wr_valid;
			mem_wr_addr <= next_wr_addr;
			mem_wr_data <= next_wr_data;
			tail_rd_req <= next_rd_req;
			reload_valid <= next_rl_valid;
			reload <= next_rl;
			event_interval_field <= next_ivl;
			threshold_irq <= next_irq;
			lfsr <= next_lfsr;
			timestamp_width_field <= prr_pkg::TS_WIDTH_CODE;
			record_size_field <= prr_pkg::REC_SIZE_FIELD;
		end
	end

	// =====================================
	// Checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	property p_id_valid;
		mem_wr_valid |-> mem_wr_data.id != prr_pkg::ID_INVALID;
	endproperty
	a_id_valid: assert property (p_id_valid) else $error("zero event id stored");

	property p_core;
		$rose(mem_wr_valid) |-> mem_wr_data.core == $past(core_identifier_field);
	endproperty
	a_core: assert property (p_core) else $error("core byte not copied");

	property p_ts_off;
		mem_wr_valid && !ts_q |-> mem_wr_data.ts == 64'h0;
	endproperty
	a_ts_off: assert property (p_ts_off) else $error("timestamp not zero");

	property p_sync_full;
		state == ST_CHECK && fresh && full_c && !continuous_mode_flag_q
			|=> missed_record_count == $past(missed_record_count) + 64'h1
			&& head_ptr == $past(head_ptr) && !mem_wr_valid;
	endproperty
	a_sync_full: assert property (p_sync_full) else $error("full buffer overwritten");

	property p_refresh;
		$rose(mem_wr_valid) && full_c && !continuous_mode_flag_q |-> 1'b0;
	endproperty
	a_refresh: assert property (p_refresh) else $error("store into full buffer");

	property p_fetch;
		state == ST_CHECK && (full_c || thr_c) && !fresh |=> ##1 tail_rd_req;
	endproperty
	a_fetch: assert property (p_fetch) else $error("tail not refreshed");

	property p_head_step;
		state == ST_STORE && mem_wr_ready
			|=> head_ptr == adv($past(head_ptr), buf_size) ##1 reload_valid;
	endproperty
	a_head_step: assert property (p_head_step) else $error("head step or reload wrong");

	property p_reload_cause;
		reload_valid |-> $past(state, 1) == ST_RELOAD
			&& ($past(missed_record_count, 2) != $past(missed_record_count, 1)
			|| $past(head_ptr, 2) != $past(head_ptr, 1)
			|| $past(mem_wr_valid, 2));
	endproperty
	a_reload_cause: assert property (p_reload_cause) else $error("reload without cause");

	property p_min;
		reload_valid && $past(ent.ev.id) != prr_pkg::ID_VALUE
			|-> reload.value >= prr_pkg::MIN_INTERVAL && event_interval_field == reload.value;
	endproperty
	a_min: assert property (p_min) else $error("reload below minimum");

	property p_irq;
		threshold_irq |-> $past(thr_int_enable) && $past(thr_c);
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt without threshold");

	property p_reserved;
		mem_wr_valid && mem_wr_data.id == prr_pkg::ID_INSTR
			|-> mem_wr_data.flags == 16'h0 && mem_wr_data.eaddr == 64'h0;
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved field not zero");

	c_store: cover property (mem_wr_valid && mem_wr_ready);
	c_drop: cover property (state == ST_CHECK && fresh && full_c && !continuous_mode_flag_q);
	c_wrap: cover property (state == ST_STORE && mem_wr_ready && continuous_mode_flag_q && full_c);
	c_irq: cover property (threshold_irq);
endmodule
`default_nettype wire

/* rtl/prr_pkg.sv */
// Shared constants and types of the profiling event ring recorder
`default_nettype none
package prr_pkg;
	// =====================================
	// Record format and capability fields
	localparam logic [31:0] REC_BYTES = 32'h0000_0020;
	localparam logic [7:0] REC_SIZE_FIELD = 8'h20;
	localparam logic [1:0] TS_WIDTH_CODE = 2'h1;
	localparam int TS_BITS = 40 + 8 * int'(TS_WIDTH_CODE);
	// =====================================
	// Event identifiers
	localparam logic [7:0] ID_INVALID = 8'h00;
	localparam logic [7:0] ID_VALUE = 8'h01;
	localparam logic [7:0] ID_INSTR = 8'h02;
	localparam logic [7:0] ID_BRANCH = 8'h03;
	localparam logic [7:0] ID_DMISS = 8'h04;
	localparam logic [7:0] ID_CORE_CLK = 8'h05;
	localparam logic [7:0] ID_REF_CLK = 8'h06;
	localparam logic [7:0] ID_PROG = 8'hFF;
	// =====================================
	// Reload policy
	localparam logic [31:0] MIN_INTERVAL = 32'h0000_0100;
	localparam int RAND_BITS = 4;
	localparam logic [31:0] OVERRUN_EDGE = 32'hFFFF_FFFF;
	// =====================================
	// Timing and reset values
	localparam int CLK_PERIOD_NS = 10;
	localparam int TS_PERIOD_NS = 10;
	localparam int TS_DIV = (TS_PERIOD_NS / CLK_PERIOD_NS < 1) ? 1
		: TS_PERIOD_NS / CLK_PERIOD_NS;
	localparam logic [7:0] TS_DIV_LAST = 8'(TS_DIV - 1);
	localparam logic [31:0] HEAD_RST = 32'h0000_0000;
	localparam logic [63:0] MISSED_RST = 64'h0;
	localparam logic [15:0] LFSR_RST = 16'hACE1;
	// =====================================
	// Carriers
	typedef struct packed {
		logic [7:0] id;
		logic [15:0] flags;
		logic [31:0] data;
		logic [63:0] iaddr;
		logic [63:0] eaddr;
		logic [2:0] slot;
		logic signed [31:0] count;
		logic [31:0] interval;
		logic rand_en;
	} prr_event_t;
	typedef struct packed {
		prr_event_t ev;
		logic [63:0] ts;
	} prr_entry_t;
	typedef struct packed {
		logic [63:0] ts;
		logic [63:0] eaddr;
		logic [63:0] iaddr;
		logic [31:0] data;
		logic [15:0] flags;
		logic [7:0] core;
		logic [7:0] id;
	} prr_record_t;
	typedef struct packed {
		logic [2:0] slot;
		logic [31:0] value;
	} prr_reload_t;
endpackage
`default_nettype wire

/* rtl/prr_buf.sv */
// Two-entry buffer between event intake and the record store
`default_nettype none
module prr_buf (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic in_valid,
	input wire prr_pkg::prr_entry_t in_data,
	output logic in_ready,
	output logic out_valid,
	output prr_pkg::prr_entry_t out_data,
	input wire logic out_ready
);
	prr_pkg::prr_entry_t mem [2];
	prr_pkg::prr_entry_t next_mem [2];
	logic wr_idx, rd_idx, next_wr_idx, next_rd_idx;
	logic [1:0] cnt, next_cnt;
	logic next_in_ready;
	logic push, pop;

	assign out_valid = cnt != 2'h0;
	assign out_data = mem[rd_idx];

	always_comb begin
		push = in_valid & in_ready;
		pop = out_ready & (cnt != 2'h0);
		next_mem = mem;
		next_wr_idx = wr_idx;
		next_rd_idx = rd_idx;
		if (push) begin
			next_mem[wr_idx] = in_data;
			next_wr_idx = ~wr_idx;
		end
		if (pop) begin
			next_rd_idx = ~rd_idx;
		end
		next_cnt = cnt + {1'b0, push} - {1'b0, pop};
		next_in_ready = next_cnt != 2'h2;
	end

	always_ff @(posedge clk_sys) begin
		mem <= next_mem;
		if (!rst_n) begin
			wr_idx <= 1'b0;
			rd_idx <= 1'b0;
			cnt <= 2'h0;
			in_ready <= 1'b1;
		end else begin
			wr_idx <= next_wr_idx;
			rd_idx <= next_rd_idx;
			cnt <= next_cnt;
			in_ready <= next_in_ready;
		end
	end
endmodule
`default_nettype wire

/* rtl/prr_tsc.sv */
// Free-running performance timestamp counter
`default_nettype none
module prr_tsc (
	input wire logic clk_sys,
	input wire logic rst_n,
	output logic [63:0] stamp
);
	logic [prr_pkg::TS_BITS-1:0] cnt, next_cnt;
	logic [7:0] div, next_div;
	logic tick;

	// Zero-extended copy; no write path exists, only reset clears it
	assign stamp = 64'(cnt);

	always_comb begin
		tick = div == prr_pkg::TS_DIV_LAST;
		next_div = tick ? 8'h00 : div + 8'h01;
		next_cnt = tick ? cnt + 1'b1 : cnt;
	end

	// Cleared only at processor initialization
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			div <= 8'h00;
			cnt <= '0;
		end else begin
			div <= next_div;
			cnt <= next_cnt;
		end
	end

	property p_tick;
		@(posedge clk_sys) disable iff (!rst_n)
		tick |=> cnt == $past(cnt) + 1'b1;
	endproperty
	a_tick: assert property (p_tick) else $error("timestamp missed a tick");
endmodule
`default_nettype wire

/* verif/prr_mem_model.sv */
// Memory and software model on the far side of the ring recorder
`default_nettype none
module prr_mem_model (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic hold,
	input wire logic [31:0] tail_value,
	input wire logic mem_wr_valid,
	output logic mem_wr_ready,
	input wire logic tail_rd_req,
	output logic tail_rd_valid,
	output logic [31:0] tail_rd_data
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [31:0] lfsr = 32'h1D2C_3B4A;
	logic [1:0] wait_cnt = 2'h0;
	logic pend = 1'b0;
	initial begin
		mem_wr_ready = 1'b0;
		tail_rd_valid = 1'b0;
		tail_rd_data = 32'h0;
	end
	// =====================================
	// Random write stalls, delayed tail answers
	always @(posedge clk_sys) begin
		lfsr <= {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		mem_wr_ready <= rst_n && !hold && lfsr[0];
		tail_rd_valid <= 1'b0;
		tail_rd_data <= ~tail_rd_data;
		if (!rst_n) begin
			pend <= 1'b0;
		end else if (tail_rd_req) begin
			pend <= 1'b1;
			wait_cnt <= lfsr[3:2];
		end else if (pend && wait_cnt == 2'h0) begin
			pend <= 1'b0;
			tail_rd_valid <= 1'b1;
			tail_rd_data <= tail_value;
		end else if (pend) begin
			wait_cnt <= wait_cnt - 2'h1;
		end
	end
endmodule
`default_nettype wire

/* verif/prr_recorder_tb_top.sv */
// Self-checking bench of the profiling event ring recorder
`default_nettype none
module prr_recorder_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {
		logic [63:0] addr;
		prr_pkg::prr_record_t rec;
		logic ts_on;
	} prr_exp_t;
	logic clk_sys, rst_n, prof_enable, continuous_mode_flag, timestamp_enable_flag;
	logic thr_int_enable, evt_valid, evt_ready, mem_wr_valid, mem_wr_ready, tail_rd_req;
	logic tail_rd_valid, reload_valid, threshold_irq, hold, refused;
	logic [7:0] core_identifier_field, record_size_field;
	logic [63:0] buf_base, missed_init, mem_wr_addr, missed_record_count, m_missed, last_ts;
	logic [31:0] buf_size, threshold, head_init, tail_rd_data, head_ptr, event_interval_field;
	logic [31:0] tail_value, m_head, msk;
	logic [31:0] lv = 32'h0;
	logic [31:0] lm = 32'hFFFF_FFFF;
	logic [31:0] rng = 32'h0000_CD7E;
	logic [1:0] timestamp_width_field;
	logic [7:0] ids[7];
	prr_pkg::prr_event_t evt;
	prr_pkg::prr_record_t mem_wr_data;
	prr_pkg::prr_reload_t reload, r;
	prr_pkg::prr_reload_t rq[$];
	prr_exp_t eq[$];
	prr_exp_t x;
	logic [31:0] rm[$];
	int err_total = 0;
	int samples_checked = 0;
	int cycles = 0;
	int irq_cnt = 0;
	int rd_cnt = 0;

	prr_recorder u_prr_recorder (.clk_sys, .rst_n, .prof_enable, .continuous_mode_flag,
		.timestamp_enable_flag, .thr_int_enable, .core_identifier_field, .buf_base, .buf_size,
		.threshold, .head_init, .missed_init, .evt_valid, .evt, .evt_ready, .mem_wr_valid,
		.mem_wr_addr, .mem_wr_data, .mem_wr_ready, .tail_rd_req, .tail_rd_valid, .tail_rd_data,
		.head_ptr, .missed_record_count, .reload_valid, .reload, .event_interval_field,
		.threshold_irq, .timestamp_width_field, .record_size_field);
	prr_mem_model u_prr_mem_model (.clk_sys, .rst_n, .hold, .tail_value, .mem_wr_valid,
		.mem_wr_ready, .tail_rd_req, .tail_rd_valid, .tail_rd_data);

	// =====================================
	// Helpers
	function automatic logic [31:0] rnd();
		rng = rng ^ (rng << 13);
		rng = rng ^ (rng >> 17);
		rng = rng ^ (rng << 5);
		return rng;
	endfunction
	task automatic check(input logic [255:0] seen, input logic [255:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish();
		if (err_total == 0 && samples_checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic start(input logic c, input logic t, input logic [63:0] m);
		prof_enable = 1'b0;
		continuous_mode_flag = c;
		timestamp_enable_flag = t;
		missed_init = m;
		tail_value = 32'h0;
		m_head = 32'h0;
		m_missed = m;
		repeat (2) @(posedge clk_sys);
		#1;
		prof_enable = 1'b1;
		@(posedge clk_sys);
		#1;
	endtask
	// Drive one event and note what it must produce
	task automatic send(input logic [7:0] id, input logic signed [31:0] cnt,
			input logic [31:0] ivl, input logic ro);
		prr_pkg::prr_event_t e;
		logic [31:0] v;
		logic full;
		e = '{id: id, flags: 16'(rnd()), data: rnd(), iaddr: {rnd(), rnd()},
			eaddr: {rnd(), rnd()}, slot: 3'(rnd()), count: cnt, interval: ivl, rand_en: ro};
		@(posedge clk_sys);
		#1;
		evt = e;
		evt_valid = 1'b1;
		do @(posedge clk_sys); while (!evt_ready);
		if (prof_enable && cnt < 0 && id != 8'h00) begin
			full = ((m_head + 32'h20) % buf_size) == tail_value;
			if (!full || continuous_mode_flag) begin
				x.addr = buf_base + 64'(m_head);
				x.rec = '{ts: 64'h0, eaddr: e.eaddr, iaddr: e.iaddr, data: e.data,
					flags: e.flags, core: core_identifier_field, id: id};
				if (id == 8'h02) begin
					x.rec.flags = 16'h0;
					x.rec.data = 32'h0;
					x.rec.eaddr = 64'h0;
				end
				x.ts_on = timestamp_enable_flag;
				eq.push_back(x);
				m_head = (m_head + 32'h20) % buf_size;
			end
			m_missed = m_missed + 64'(full);
			v = (cnt < -1) ? ivl + 32'(cnt) + 32'h1 : ivl;
			if (id != 8'h01 && v < 32'h100) begin
				v = 32'h100;
			end
			lv = v;
			lm = ro ? 32'hFFFF_FFF0 : 32'hFFFF_FFFF;
			rq.push_back('{slot: e.slot, value: v});
			rm.push_back(lm);
		end
		#1;
		evt_valid = 1'b0;
	endtask
	task automatic wait_done();
		for (int n = 0; n < 300 && eq.size() + rq.size() != 0; n++) @(posedge clk_sys);
		repeat (3) @(posedge clk_sys);
		#1;
		check(head_ptr, m_head);
		check(missed_record_count, m_missed);
		check(event_interval_field & lm, lv & lm);
	endtask

	// =====================================
	// Clock and output watcher
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) begin
		cycles++;
		if (rst_n && threshold_irq) irq_cnt++;
		if (rst_n && tail_rd_req) rd_cnt++;
		if (evt_valid && !evt_ready) refused = 1'b1;
		if (rst_n && mem_wr_valid && mem_wr_ready) begin
			if (eq.size() == 0) begin
				check(eq.size(), 1);
			end else begin
				x = eq.pop_front();
				check(mem_wr_addr, x.addr);
				check(mem_wr_data[191:0], x.rec[191:0]);
				if (x.ts_on) begin
					check(mem_wr_data.ts[63:48], 16'h0);
					check(mem_wr_data.ts > last_ts, 1'b1);
					last_ts = mem_wr_data.ts;
				end else begin
					check(mem_wr_data.ts, 64'h0);
				end
			end
		end
		if (rst_n && reload_valid) begin
			if (rq.size() == 0) begin
				check(rq.size(), 1);
			end else begin
				r = rq.pop_front();
				msk = rm.pop_front();
				check(reload.slot, r.slot);
				check(reload.value & msk, r.value & msk);
			end
		end
		if (cycles == 20000) begin
			check(cycles, 0);
			tally_and_finish();
		end
	end

	// =====================================
	// Main sequence
	initial begin
		ids = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'hFF};
		rst_n = 1'b0;
		prof_enable = 1'b0;
		continuous_mode_flag = 1'b0;
		timestamp_enable_flag = 1'b0;
		head_init = 32'h0;
		missed_init = 64'h0;
		evt_valid = 1'b0;
		evt = '0;
		hold = 1'b0;
		refused = 1'b0;
		thr_int_enable = 1'b1;
		core_identifier_field = 8'h5A;
		buf_base = 64'h0000_0000_8000_0000;
		buf_size = 32'h0000_0080;
		threshold = 32'h0000_0040;
		tail_value = 32'h0;
		last_ts = 64'h0;
		repeat (10) @(posedge clk_sys);
		#1;
		rst_n = 1'b1;
		check(timestamp_width_field, 2'h1);
		check(record_size_field, 8'h20);
		start(1'b0, 1'b0, 64'h5);
		send(8'h00, -2, 32'h1000, 1'b0);
		send(8'h02, 0, 32'h1000, 1'b0);
		for (int i = 0; i < 7; i++) begin
			if (i == 2) check(irq_cnt, 0);
			if (i == 4) tail_value = 32'h40;
			send(ids[i], 32'(-1 - 3 * i), (i < 2) ? 32'h10 << i : 32'h1000 + i, 1'b0);
			wait_done();
		end
		check(irq_cnt != 0, 1'b1);
		check(rd_cnt != 0, 1'b1);
		prof_enable = 1'b0;
		send(8'h03, -5, 32'h1000, 1'b0);
		wait_done();
		buf_base = 64'h0000_0000_9000_0000;
		core_identifier_field = 8'hA5;
		thr_int_enable = 1'b0;
		start(1'b1, 1'b1, 64'h0);
		for (int i = 0; i < 9; i++) begin
			if (i == 5) begin
				hold = 1'b1;
				fork
					begin
						repeat (60) @(posedge clk_sys);
						#1;
						hold = 1'b0;
					end
				join_none
			end
			send(ids[i % 7], -1, 32'h2000, i[0]);
			if (i < 5) wait_done();
		end
		wait_done();
		check(refused, 1'b1);
		check(missed_record_count != 64'h0, 1'b1);
		check(eq.size() + rq.size(), 0);
		tally_and_finish();
	end
endmodule
`default_nettype wire
